// *** dv/prog_mem_model.sv ***
// Purpose: program memory and interrupt source facing the sequencer
// Assumes: the bench loads words before it releases reset
// Notes:   the request stays up until the sequencer acknowledges it
`timescale 1ns/1ns
module prog_mem_model import seq_pkg::*; (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic [PC_W-1:0]    prog_addr,
	output logic      [INSTR_W-1:0] prog_rdata,
	input  wire logic               irq_raise,
	input  wire logic               irq_ack,
	output logic                    irq_req
);
	logic [INSTR_W-1:0] mem [0:2**PC_W-1];
	logic               irq_held;

	// ----------------------------------------
	// Fetch and interrupt request
	// ----------------------------------------
	assign prog_rdata = mem[prog_addr];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_held <= 1'b0;
		end else if (irq_raise) begin
			irq_held <= 1'b1;
		end else if (irq_ack) begin
			irq_held <= 1'b0;
		end
	end

	// Request drops in the acknowledge cycle so the sticky flag can clear
	assign irq_req = irq_held & ~irq_ack;
endmodule

// *** dv/tb_program_sequencer_pc_stack.sv ***
// Purpose: self-checking bench of the program sequencer
// Assumes: zero-wait APB slave, fetch traced at each T1
// Notes:   each scenario loads its own program and resets
`timescale 1ns/1ns
module tb_program_sequencer_pc_stack import seq_pkg::*;;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic               irq_req, irq_ack, irq_raise, err;
	logic [ADDR_W-1:0]  paddr;
	logic [BUS_W-1:0]   pwdata, prdata, rd;
	logic [PC_W-1:0]    prog_addr;
	logic [INSTR_W-1:0] prog_rdata;
	logic [3:0]         instruction_phases;
	logic [PC_W-1:0]    trace[$], exp_q[$];
	int                 miscompares, n_checks, n;

	program_sequencer_pc_stack dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .irq_req(irq_req),
		.irq_ack(irq_ack), .instruction_phases(instruction_phases));
	prog_mem_model mem_model (.pclk(pclk), .presetn(presetn), .prog_addr(prog_addr),
		.prog_rdata(prog_rdata), .irq_raise(irq_raise), .irq_ack(irq_ack), .irq_req(irq_req));

	// ----------------------------------------
	// Clock, trace and shared tasks
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(negedge pclk) begin
		if (instruction_phases === 4'b0001) trace.push_back(prog_addr);
	end

	function automatic logic [15:0] jump_op(input logic [3:0] op, input logic [10:0] a);
		return {op, 1'b0, a};
	endfunction

	function automatic bit found();
		for (int i = 0; i + exp_q.size() <= trace.size(); i++) begin
			found = 1'b1;
			for (int j = 0; j < exp_q.size(); j++) if (trace[i+j] !== exp_q[j]) found = 1'b0;
			if (found) return 1'b1;
		end
		return 1'b0;
	endfunction

	task check(input string what, input logic [31:0] seen, input logic [31:0] expd);
		n_checks++;
		if (seen !== expd) begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", what, expd, seen);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task load(input logic [10:0] a, input logic [15:0] w);
		mem_model.mem[a] = w;
	endtask

	task start();
		for (int i = 0; i < 2**PC_W; i++) mem_model.mem[i] = 16'h0000;
	endtask

	task do_reset();
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		check("reset fetch address", 32'(prog_addr), 32'h0);
		trace.delete();
		presetn <= 1'b1;
	endtask

	task results();
		$display("Checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task plain_jump();
		start();
		load(11'h003, jump_op(OP_JUMP, 11'h010));
		load(11'h014, jump_op(OP_JUMP, 11'h014));
		do_reset();
		repeat (40) @(posedge pclk);
		exp_q = '{11'h001, 11'h002, 11'h003, 11'h004, 11'h010, 11'h011, 11'h012};
		check("jump fetch trace", 32'(found()), 32'h1);
	endtask

	task call_stack();
		start();
		load(11'h000, jump_op(OP_JUMP, 11'h010));
		load(11'h004, {OP_INTERRUPT_RETURN, 12'h000});
		for (int k = 1; k <= 7; k++) begin
			load(11'(16*k), jump_op(OP_CALL, 11'(16*k+16)));
			load(11'(16*k+1), {OP_SUBROUTINE_RETURN, 12'h000});
		end
		load(11'h021, jump_op(OP_JUMP, 11'h021));
		load(11'h088, {OP_SUBROUTINE_RETURN, 12'h000});
		do_reset();
		while (prog_addr !== 11'h081) @(posedge pclk);
		apb(1'b1, REG_CTRL, 32'h1);
		irq_raise <= 1'b1;
		@(posedge pclk);
		irq_raise <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0);
		check("deferred pending flag", 32'(rd[ST_IRQ_PEND]), 32'h1);
		n = 0;
		while (prog_addr !== 11'h088) begin
			@(posedge pclk);
			if (irq_ack === 1'b1) n++;
		end
		check("ack with full stack", n, 0);
		repeat (200) @(posedge pclk);
		exp_q = '{11'h070, 11'h071};
		for (int a = 'h80; a <= 'h89; a++) exp_q.push_back(11'(a));
		exp_q = {exp_q, 11'h071, 11'h004, 11'h005, 11'h071, 11'h072};
		for (int a = 'h61; a >= 'h21; a -= 'h10) exp_q = {exp_q, 11'(a), 11'(a+1)};
		check("call return trace", 32'(found()), 32'h1);
	endtask

	task alu_skip();
		start();
		load(11'h001, {OP_ALU_ACC, ALU_AND, 8'h00});
		load(11'h002, {OP_ALU_WORK, ALU_AND, 8'h00});
		load(11'h003, {OP_SKIP, SKIP_IF_ZERO_OP, 8'h00});
		load(11'h004, {OP_ALU_ACC, ALU_OR, 8'hFF});
		load(11'h005, {OP_ALU_ACC, ALU_OR, 8'h09});
		load(11'h006, {OP_SKIP, INCREMENT_SKIP_ZERO_OP, 8'h00});
		load(11'h007, {OP_ALU_ACC, ALU_ADD, 8'h01});
		load(11'h008, {OP_ALU_ACC, DECIMAL_ADJUST_OP, 8'h00});
		load(11'h009, {OP_ALU_ACC, ALU_ADD, 8'hF0});
		load(11'h00A, jump_op(OP_JUMP, 11'h00A));
		do_reset();
		repeat (80) @(posedge pclk);
		apb(1'b0, REG_ACC, 32'h0);
		check("accumulator", rd, 32'h0);
		apb(1'b0, REG_WORK, 32'h0);
		check("work register", rd, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		check("carry and zero", 32'(rd[1:0]), 32'h3);
	endtask

	task pc_low();
		start();
		load(11'h000, jump_op(OP_JUMP, 11'h120));
		load(11'h121, {OP_PC_LOW_WRITE, 4'h0, 8'h40});
		load(11'h150, jump_op(OP_JUMP, 11'h150));
		load(11'h180, jump_op(OP_JUMP, 11'h180));
		do_reset();
		apb(1'b0, REG_CTRL, 32'h0);
		check("control reset", rd, 32'h0);
		repeat (60) @(posedge pclk);
		exp_q = '{11'h121, 11'h122, 11'h140, 11'h141};
		check("low byte jump trace", 32'(found()), 32'h1);
		apb(1'b1, REG_PC_LOW_BYTE, 32'h80);
		repeat (40) @(posedge pclk);
		exp_q = '{11'h180, 11'h181, 11'h180};
		check("bus low byte jump", 32'(found()), 32'h1);
		apb(1'b0, REG_PC_LOW_BYTE, 32'h0);
		check("low byte read", 32'(rd[7:1]), 32'h40);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped error", 32'(err), 32'h1);
		check("unmapped data", rd, 32'h0);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, irq_raise} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		miscompares = 0;
		n_checks = 0;
		plain_jump();
		call_stack();
		alu_skip();
		pc_low();
		results();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		results();
	end
endmodule

// *** hw/alu8.sv ***
// Purpose: 8-bit arithmetic and logic unit
// Assumes: combinational, used once per instruction cycle
// Notes:   carry means no borrow on subtraction
`timescale 1ns/1ns
module alu8 import seq_pkg::*; (
	input  wire logic [3:0]        func,
	input  wire logic [DATA_W-1:0] a,
	input  wire logic [DATA_W-1:0] b,
	input  wire logic              c_in,
	output logic      [DATA_W-1:0] result,
	output alu_flags_s             flags,
	output logic                   skip
);

	logic [DATA_W:0]   sum;
	logic [DATA_W-1:0] adj;

	always_comb begin
		sum         = '0;
		adj         = '0;
		result      = '0;
		flags.carry = c_in;
		case (func)
			ALU_ADD, ALU_ADC: begin
				sum         = {1'b0, a} + {1'b0, b} + {8'h00, c_in & func[0]};
				result      = sum[DATA_W-1:0];
				flags.carry = sum[DATA_W];
			end
			ALU_SUB, ALU_SBC: begin
				sum         = {1'b0, a} + {1'b0, ~b} + {8'h00, func[0] ? c_in : 1'b1};
				result      = sum[DATA_W-1:0];
				flags.carry = sum[DATA_W];
			end
			DECIMAL_ADJUST_OP: begin
				if (a[3:0] > NIBBLE_MAX) begin
					adj = DAA_LOW;
				end
				if (a[7:4] > NIBBLE_MAX || c_in) begin
					adj = adj | DAA_HIGH;
				end
				sum         = {1'b0, a} + {1'b0, adj};
				result      = sum[DATA_W-1:0];
				flags.carry = sum[DATA_W] | c_in;
			end
			ALU_AND: result = a & b;
			ALU_OR:  result = a | b;
			ALU_XOR: result = a ^ b;
			ALU_CPL: result = ~b;
			INCREMENT_SKIP_ZERO_OP: result = b + 8'h01;
			DECREMENT_SKIP_ZERO_OP: result = b - 8'h01;
			ALU_RR:  result = {b[0], b[7:1]};
			ALU_RRC: begin
				result      = {c_in, b[7:1]};
				flags.carry = b[0];
			end
			ALU_RL:  result = {b[6:0], b[7]};
			ALU_RLC: begin
				result      = {b[6:0], c_in};
				flags.carry = b[7];
			end
			default: result = b;
		endcase
		flags.zero = (result == '0);
		skip       = (func == SKIP_IF_ZERO_OP) ? (b == '0) : flags.zero;
	end

endmodule

// *** hw/program_sequencer_pc_stack.sv ***
// Purpose: program sequencer with prefetch, PC, return stack and ALU
// Assumes: program memory answers within the instruction cycle
// Notes:   registers on APB; zero-wait slave
`timescale 1ns/1ns
module program_sequencer_pc_stack import seq_pkg::*; (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [BUS_W-1:0]   pwdata,
	output logic      [BUS_W-1:0]   prdata,
	output logic                    pready,
	output logic                    pslverr,
	output logic      [PC_W-1:0]    prog_addr,
	input  wire logic [INSTR_W-1:0] prog_rdata,
	input  wire logic               irq_req,
	output logic                    irq_ack,
	output logic      [3:0]         instruction_phases
);

	phase_e            phase;
	logic [PC_W-1:0]   pc;
	logic [PC_W-1:0]   next_pc;
	logic [PC_W-1:0]   jump_target;
	logic [PC_W-1:0]   pcl_target;
	instr_s            ir;
	logic              ir_valid;
	logic              next_valid;
	logic              boundary;
	logic              exec;
	logic              branch_op;
	logic [DATA_W-1:0] acc;
	logic [DATA_W-1:0] wreg;
	alu_flags_s        flags;
	logic              irq_pending;
	logic              irq_en;
	logic              pcl_pending;
	logic [DATA_W-1:0] pcl_data;
	logic              take_irq;
	logic              take_pcl;
	logic              stack_push;
	logic              stack_pop;
	logic [PC_W-1:0]   stack_top;
	logic              stack_full;
	logic [DATA_W-1:0] alu_b;
	logic [DATA_W-1:0] alu_result;
	alu_flags_s        alu_flags;
	logic              alu_skip;
	logic              wr_access;
	logic              mapped;
	logic [BUS_W-1:0]  rd_word;

	// ------------------------------------------------------------
	// Instruction phases
	// ------------------------------------------------------------

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= PH_T4;
		end else begin
			case (phase)
				PH_T1:   phase <= PH_T2;
				PH_T2:   phase <= PH_T3;
				PH_T3:   phase <= PH_T4;
				PH_T4:   phase <= PH_T1;
				default: phase <= PH_T1;
			endcase
		end
	end

	assign instruction_phases = 4'h1 << phase;
	assign boundary           = (phase == PH_T4);
	assign exec               = boundary & ir_valid;

	// ------------------------------------------------------------
	// Next program counter
	// ------------------------------------------------------------

	assign jump_target = {ir.func[PAGE_W-1:0], ir.imm};
	assign pcl_target  = {pc[PC_W-1:DATA_W], pcl_data};

	always_comb begin
		case (ir.op)
			OP_JUMP, OP_CALL, OP_SUBROUTINE_RETURN,
			OP_INTERRUPT_RETURN, OP_PC_LOW_WRITE: branch_op = exec;
			default:                              branch_op = 1'b0;
		endcase
	end

	always_comb begin
		next_pc    = pc;
		next_valid = ir_valid;
		stack_push = 1'b0;
		stack_pop  = 1'b0;
		take_irq   = 1'b0;
		take_pcl   = 1'b0;
		if (boundary) begin
			next_pc    = pc + PC_STEP;
			next_valid = 1'b1;
		end
		if (exec) begin
			case (ir.op)
				OP_JUMP: begin
					next_pc    = jump_target;
					next_valid = 1'b0;
				end
				OP_CALL: begin
					next_pc    = jump_target;
					next_valid = 1'b0;
					stack_push = 1'b1;
				end
				OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
					next_pc    = stack_top;
					next_valid = 1'b0;
					stack_pop  = 1'b1;
				end
				OP_PC_LOW_WRITE: begin
					next_pc    = {pc[PC_W-1:DATA_W], ir.imm};
					next_valid = 1'b0;
				end
				OP_SKIP: begin
					if (alu_skip) begin
						next_valid = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (boundary && !branch_op) begin
			if (pcl_pending) begin
				take_pcl   = 1'b1;
				next_pc    = pcl_target;
				next_valid = 1'b0;
			end else if (irq_pending && irq_en && !stack_full) begin
				take_irq   = 1'b1;
				stack_push = 1'b1;
				next_pc    = INT_VECTOR;
				next_valid = 1'b0;
			end
		end
	end

	assign irq_ack = take_irq;

	// ------------------------------------------------------------
	// Fetch and prefetch register
	// ------------------------------------------------------------

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= RESET_VECTOR;
		end else if (boundary) begin
			pc <= next_pc;
		end
	end

	assign prog_addr = pc;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir       <= '0;
			ir_valid <= 1'b0;
		end else if (boundary) begin
			ir       <= prog_rdata;
			ir_valid <= next_valid;
		end
	end

	// ------------------------------------------------------------
	// Data path
	// ------------------------------------------------------------

	assign alu_b = (ir.op == OP_ALU_ACC) ? ir.imm : wreg;

	alu8 u_alu (
		.func   (ir.func),
		.a      (acc),
		.b      (alu_b),
		.c_in   (flags.carry),
		.result (alu_result),
		.flags  (alu_flags),
		.skip   (alu_skip)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= '0;
		end else if (exec && ir.op == OP_ALU_ACC) begin
			acc <= alu_result;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wreg <= '0;
		end else if (exec && ir.op == OP_ALU_WORK) begin
			wreg <= alu_result;
		end else if (exec && ir.op == OP_SKIP && ir.func != SKIP_IF_ZERO_OP) begin
			wreg <= alu_result;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
		end else if (exec && (ir.op == OP_ALU_ACC || ir.op == OP_ALU_WORK)) begin
			flags <= alu_flags;
		end
	end

	// ------------------------------------------------------------
	// Return stack and interrupt flag
	// ------------------------------------------------------------

	return_stack u_stack (
		.pclk      (pclk),
		.presetn   (presetn),
		.push      (stack_push),
		.pop       (stack_pop),
		.push_data (pc),
		.top       (stack_top),
		.full      (stack_full)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pending <= 1'b0;
		end else if (irq_req) begin
			irq_pending <= 1'b1;
		end else if (take_irq) begin
			irq_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// APB registers
	// ------------------------------------------------------------

	assign wr_access = psel & penable & pwrite;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcl_pending <= 1'b0;
			pcl_data    <= '0;
		end else if (wr_access && paddr == REG_PC_LOW_BYTE) begin
			pcl_pending <= 1'b1;
			pcl_data    <= pwdata[DATA_W-1:0];
		end else if (take_pcl) begin
			pcl_pending <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en <= 1'b0;
		end else if (wr_access && paddr == REG_CTRL) begin
			irq_en <= pwdata[CTRL_IRQ_EN];
		end
	end

	always_comb begin
		rd_word = '0;
		mapped  = 1'b1;
		case (paddr)
			REG_PC_LOW_BYTE: rd_word[DATA_W-1:0] = pc[DATA_W-1:0];
			REG_CTRL:        rd_word[CTRL_IRQ_EN] = irq_en;
			REG_STATUS: begin
				rd_word[ST_CARRY]             = flags.carry;
				rd_word[ST_ZERO]              = flags.zero;
				rd_word[ST_IRQ_PEND]          = irq_pending;
				rd_word[ST_PHASE +: PHASE_W]  = phase;
			end
			REG_ACC:  rd_word[DATA_W-1:0] = acc;
			REG_WORK: rd_word[DATA_W-1:0] = wreg;
			default:  mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			prdata <= rd_word;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	a_phase_order: assert property (@(posedge pclk) disable iff (!presetn)
		phase == PH_T1 |=> phase == PH_T2 ##1 phase == PH_T3 ##1 phase == PH_T4 ##1 phase == PH_T1)
		else $error("phase order broken");

	a_pc_hold: assert property (@(posedge pclk) disable iff (!presetn)
		phase != PH_T4 |=> $stable(pc)) else $error("pc moved inside cycle");

	a_plain_throughput: assert property (@(posedge pclk) disable iff (!presetn)
		exec && ir.op == OP_ALU_ACC && !pcl_pending && !take_irq |=> ir_valid)
		else $error("plain instruction stalled");

	a_jump_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
		exec && ir.op == OP_JUMP && !pcl_pending && !irq_pending |=> !ir_valid [*4] ##1 ir_valid)
		else $error("jump not two cycles");

	a_pc_step: assert property (@(posedge pclk) disable iff (!presetn)
		exec && ir.op == OP_NOP && !pcl_pending && !take_irq |=> pc == PC_W'($past(pc) + PC_STEP))
		else $error("pc did not step by one");

	a_jump_target: assert property (@(posedge pclk) disable iff (!presetn)
		exec && ir.op == OP_JUMP |=> pc == $past(jump_target)) else $error("jump target wrong");

	a_skip_dummy: assert property (@(posedge pclk) disable iff (!presetn)
		exec && ir.op == OP_SKIP && alu_skip |=> !ir_valid) else $error("skip kept prefetch");

	a_pcl_page: assert property (@(posedge pclk) disable iff (!presetn)
		take_pcl |=> pc == $past(pcl_target) && !ir_valid) else $error("low byte jump wrong");

	a_ret_pop: assert property (@(posedge pclk) disable iff (!presetn)
		exec && ir.op == OP_SUBROUTINE_RETURN |=> pc == $past(stack_top)) else $error("return address wrong");

	a_irq_defer: assert property (@(posedge pclk) disable iff (!presetn)
		stack_full |-> !irq_ack) else $error("ack with full stack");

	a_alu_zero: assert property (@(posedge pclk) disable iff (!presetn)
		exec && ir.op == OP_ALU_ACC |=> flags.zero == (acc == '0)) else $error("zero flag wrong");

	a_reset_start: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> pc == RESET_VECTOR) else $error("pc not zero after reset");

endmodule

// *** hw/return_stack.sv ***
// Purpose: six-entry hardware return stack
// Assumes: push and pop never in the same cycle
// Notes:   entry 0 is the top; overflow drops the oldest entry
`timescale 1ns/1ns
module return_stack import seq_pkg::*; (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            push,
	input  wire logic            pop,
	input  wire logic [PC_W-1:0] push_data,
	output logic      [PC_W-1:0] top,
	output logic                 full
);

	logic [PC_W-1:0] entry [STACK_DEPTH];
	logic [SP_W-1:0] count;

	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_entry
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				entry[i] <= '0;
			end else if (push) begin
				if (i == 0) begin
					entry[i] <= push_data;
				end else begin
					entry[i] <= entry[(i == 0) ? 0 : i-1];
				end
			end else if (pop) begin
				if (i == STACK_DEPTH-1) begin
					entry[i] <= '0;
				end else begin
					entry[i] <= entry[(i == STACK_DEPTH-1) ? i : i+1];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= SP_EMPTY;
		end else if (push && count != SP_FULL) begin
			count <= count + SP_STEP;
		end else if (pop && count != SP_EMPTY) begin
			count <= count - SP_STEP;
		end
	end

	assign top  = entry[0];
	assign full = (count == SP_FULL);

	a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
		count <= SP_FULL) else $error("stack count above six");
	a_push_top: assert property (@(posedge pclk) disable iff (!presetn)
		push |=> top == $past(push_data)) else $error("pushed value not on top");
	a_overflow_full: assert property (@(posedge pclk) disable iff (!presetn)
		push && full |=> full && count == SP_FULL) else $error("overflow changed depth");

endmodule

// *** hw/seq_pkg.sv ***
// Purpose: shared constants and types of the program sequencer
// Assumes: one clock pclk, APB register access, 16-bit program words
// Notes:   opcode layout is {op, func, imm}; jump target is {func[2:0], imm}
package seq_pkg;

	localparam int PC_W        = 11;
	localparam int DATA_W      = 8;
	localparam int INSTR_W     = 16;
	localparam int STACK_DEPTH = 6;
	localparam int SP_W        = 3;
	localparam int PHASE_W     = 2;
	localparam int PAGE_W      = 3;
	localparam int ADDR_W      = 8;
	localparam int BUS_W       = 32;

	localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
	localparam logic [PC_W-1:0] INT_VECTOR   = 11'h004;
	localparam logic [PC_W-1:0] PC_STEP      = 11'h001;
	localparam logic [SP_W-1:0] SP_FULL      = 3'h6;
	localparam logic [SP_W-1:0] SP_EMPTY     = 3'h0;
	localparam logic [SP_W-1:0] SP_STEP      = 3'h1;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_PC_LOW_BYTE = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CTRL        = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS      = 8'h08;
	localparam logic [ADDR_W-1:0] REG_ACC         = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_WORK        = 8'h10;

	// Field positions
	localparam int CTRL_IRQ_EN = 0;
	localparam int ST_CARRY    = 0;
	localparam int ST_ZERO     = 1;
	localparam int ST_IRQ_PEND = 2;
	localparam int ST_PHASE    = 4;

	// Opcodes
	localparam logic [3:0] OP_NOP               = 4'h0;
	localparam logic [3:0] OP_ALU_ACC           = 4'h1;
	localparam logic [3:0] OP_ALU_WORK          = 4'h2;
	localparam logic [3:0] OP_JUMP              = 4'h4;
	localparam logic [3:0] OP_CALL              = 4'h5;
	localparam logic [3:0] OP_SUBROUTINE_RETURN = 4'h6;
	localparam logic [3:0] OP_INTERRUPT_RETURN  = 4'h7;
	localparam logic [3:0] OP_SKIP              = 4'h8;
	localparam logic [3:0] OP_PC_LOW_WRITE      = 4'h9;

	// ALU functions
	localparam logic [3:0] ALU_ADD           = 4'h0;
	localparam logic [3:0] ALU_ADC           = 4'h1;
	localparam logic [3:0] ALU_SUB           = 4'h2;
	localparam logic [3:0] ALU_SBC           = 4'h3;
	localparam logic [3:0] DECIMAL_ADJUST_OP = 4'h4;
	localparam logic [3:0] ALU_AND           = 4'h5;
	localparam logic [3:0] ALU_OR            = 4'h6;
	localparam logic [3:0] ALU_XOR           = 4'h7;
	localparam logic [3:0] ALU_CPL           = 4'h8;
	localparam logic [3:0] INCREMENT_SKIP_ZERO_OP = 4'h9;
	localparam logic [3:0] DECREMENT_SKIP_ZERO_OP = 4'hA;
	localparam logic [3:0] ALU_RR            = 4'hB;
	localparam logic [3:0] ALU_RRC           = 4'hC;
	localparam logic [3:0] ALU_RL            = 4'hD;
	localparam logic [3:0] ALU_RLC           = 4'hE;
	localparam logic [3:0] SKIP_IF_ZERO_OP   = 4'hF;

	localparam logic [3:0]        NIBBLE_MAX = 4'h9;
	localparam logic [DATA_W-1:0] DAA_LOW    = 8'h06;
	localparam logic [DATA_W-1:0] DAA_HIGH   = 8'h60;

	typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} phase_e;

	typedef struct packed {
		logic [3:0]        op;
		logic [3:0]        func;
		logic [DATA_W-1:0] imm;
	} instr_s;

	typedef struct packed {
		logic carry;
		logic zero;
	} alu_flags_s;

endpackage
